/* File: ktc_regs.vh */
// Offsets, field positions, reset values and codes of the training words
`ifndef KTC_REGS_VH
`define KTC_REGS_VH
// Management device address of the training words
`define KTC_DEVAD 5'h01
// Register offsets within the device address
`define KTC_PARTNER_REQ_OFS 16'h0098
`define KTC_PARTNER_RPT_OFS 16'h0099
`define KTC_LOCAL_REQ_OFS 16'h009a
`define KTC_LOCAL_RPT_OFS 16'h009b
// Reset value shared by all four words
`define KTC_WORD_RST 16'h0000
// Field positions
`define KTC_READY_BIT 15
`define KTC_PRESET_BIT 13
`define KTC_INIT_BIT 12
`define KTC_SWING_LSB 8
`define KTC_POST2_LSB 6
`define KTC_POSTC_LSB 4
`define KTC_MAIN_LSB 2
`define KTC_PREC_LSB 0
// Request codes
`define KTC_REQ_HOLD 2'h0
`define KTC_REQ_INC 2'h1
`define KTC_REQ_DEC 2'h2
// Status codes
`define KTC_ST_NONE 2'h0
`define KTC_ST_UPDATED 2'h1
`define KTC_ST_MIN 2'h2
`define KTC_ST_MAX 2'h3
`endif

/* File: ktc_training_coeff_regs.v */
// Read-only link-training coefficient request and status words
`timescale 1ns/100ps
`default_nettype none
`include "ktc_regs.vh"

////////////////////////////////////////////////////////////////////////////
module ktc_training_coeff_regs
(
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Training frame received from the partner (same clock domain)
   input wire rx_frame_valid,
   input wire partner_preset_req,
   input wire partner_init_req,
   input wire [9:0] partner_update_req,
   input wire partner_receiver_trained,
   input wire [9:0] partner_update_state,
   // Training frame sent by the local side (same clock domain)
   input wire tx_frame_valid,
   input wire local_preset_req,
   input wire local_init_req,
   input wire [9:0] local_update_req,
   input wire local_receiver_trained,
   input wire [9:0] local_update_state,
   // Management register access
   input wire mgmt_rd,
   input wire mgmt_wr,
   input wire [4:0] mgmt_devad,
   input wire [15:0] mgmt_addr,
   input wire [15:0] mgmt_wdata,
   output reg [15:0] mgmt_rdata,
   output reg mgmt_hit
);

   ////////////////////////////////////////////////////////////////////////
   // Stored words; only the defined fields are held, reserved bits are
   // built as constant zero so no write path can ever reach them
   reg partner_preset_reg; // Partner preset request
   reg partner_init_reg; // Partner initialize request
   reg [9:0] partner_req_reg; // Partner five update requests
   reg partner_ready_reg; // Partner receiver trained
   reg [9:0] partner_state_reg; // Partner five update states
   reg local_preset_reg; // Local preset request
   reg local_init_reg; // Local initialize request
   reg [9:0] local_req_reg; // Local five update requests
   reg local_ready_reg; // Local receiver trained
   reg [9:0] local_state_reg; // Local five update states

   // Assembled words seen by the host
   wire [15:0] partner_req_word;
   wire [15:0] partner_rpt_word;
   wire [15:0] local_req_word;
   wire [15:0] local_rpt_word;
   reg [15:0] rdata_next;
   reg hit_next;

   ////////////////////////////////////////////////////////////////////////
   // Capture partner fields on each received frame
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         partner_preset_reg <= 1'b0;
         partner_init_reg <= 1'b0;
         partner_req_reg <= 10'h000;
         partner_ready_reg <= 1'b0;
         partner_state_reg <= 10'h000;
      end
      else if (rx_frame_valid)
      begin
         partner_preset_reg <= partner_preset_req;
         partner_init_reg <= partner_init_req;
         // Codes pass untouched, reserved 11 stays visible
         partner_req_reg <= partner_update_req;
         partner_ready_reg <= partner_receiver_trained;
         partner_state_reg <= partner_update_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Capture local fields on each sent frame
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Requests reset to hold, flags to normal operation
         local_preset_reg <= 1'b0;
         local_init_reg <= 1'b0;
         local_req_reg <= {5{`KTC_REQ_HOLD}};
         local_ready_reg <= 1'b0;
         local_state_reg <= {5{`KTC_ST_NONE}};
      end
      else if (tx_frame_valid)
      begin
         local_preset_reg <= local_preset_req;
         local_init_reg <= local_init_req;
         local_req_reg <= local_update_req;
         local_ready_reg <= local_receiver_trained;
         local_state_reg <= local_update_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Field split; each stored vector is cut at the header's field
   // positions so the word layout below reads lane by lane and a
   // swapped lane shows up as a wrong name, not a wrong bit index
   // Partner update requests, one two-bit code per lane
   wire [1:0] partner_swing_req; // Swing lane
   wire [1:0] partner_post2_req; // Second post-cursor tap
   wire [1:0] partner_postcursor_req; // K(+1) lane
   wire [1:0] partner_main_req; // K(0) lane
   wire [1:0] partner_precursor_req; // K(-1) lane
   // Partner update states, one two-bit code per lane
   wire [1:0] partner_swing_state; // Swing lane
   wire [1:0] partner_post2_state; // Second post-cursor tap
   wire [1:0] partner_postcursor_state; // K(+1) lane
   wire [1:0] partner_main_state; // K(0) lane
   wire [1:0] partner_precursor_state; // K(-1) lane
   // Local update requests, one two-bit code per lane
   wire [1:0] local_swing_req; // Swing lane
   wire [1:0] local_post2_req; // Second post-cursor tap
   wire [1:0] local_postcursor_req; // K(+1) lane
   wire [1:0] local_main_req; // K(0) lane
   wire [1:0] local_precursor_req; // K(-1) lane
   // Local update states, one two-bit code per lane
   wire [1:0] local_swing_state; // Swing lane
   wire [1:0] local_post2_state; // Second post-cursor tap
   wire [1:0] local_postcursor_state; // K(+1) lane
   wire [1:0] local_main_state; // K(0) lane
   wire [1:0] local_precursor_state; // K(-1) lane

   // Partner requests; a reserved 11 code is passed on, not masked,
   // so the host can see a partner that sends a bad request
   assign partner_swing_req =
      partner_req_reg[`KTC_SWING_LSB+1:`KTC_SWING_LSB];
   assign partner_post2_req =
      partner_req_reg[`KTC_POST2_LSB+1:`KTC_POST2_LSB];
   assign partner_postcursor_req =
      partner_req_reg[`KTC_POSTC_LSB+1:`KTC_POSTC_LSB];
   assign partner_main_req =
      partner_req_reg[`KTC_MAIN_LSB+1:`KTC_MAIN_LSB];
   assign partner_precursor_req =
      partner_req_reg[`KTC_PREC_LSB+1:`KTC_PREC_LSB];
   // Partner states; all four status codes are meaningful
   assign partner_swing_state =
      partner_state_reg[`KTC_SWING_LSB+1:`KTC_SWING_LSB];
   assign partner_post2_state =
      partner_state_reg[`KTC_POST2_LSB+1:`KTC_POST2_LSB];
   assign partner_postcursor_state =
      partner_state_reg[`KTC_POSTC_LSB+1:`KTC_POSTC_LSB];
   assign partner_main_state =
      partner_state_reg[`KTC_MAIN_LSB+1:`KTC_MAIN_LSB];
   assign partner_precursor_state =
      partner_state_reg[`KTC_PREC_LSB+1:`KTC_PREC_LSB];
   // Local requests; hold after reset until the first sent frame
   assign local_swing_req =
      local_req_reg[`KTC_SWING_LSB+1:`KTC_SWING_LSB];
   assign local_post2_req =
      local_req_reg[`KTC_POST2_LSB+1:`KTC_POST2_LSB];
   assign local_postcursor_req =
      local_req_reg[`KTC_POSTC_LSB+1:`KTC_POSTC_LSB];
   assign local_main_req =
      local_req_reg[`KTC_MAIN_LSB+1:`KTC_MAIN_LSB];
   assign local_precursor_req =
      local_req_reg[`KTC_PREC_LSB+1:`KTC_PREC_LSB];
   // Local states; not updated after reset until the first sent frame
   assign local_swing_state =
      local_state_reg[`KTC_SWING_LSB+1:`KTC_SWING_LSB];
   assign local_post2_state =
      local_state_reg[`KTC_POST2_LSB+1:`KTC_POST2_LSB];
   assign local_postcursor_state =
      local_state_reg[`KTC_POSTC_LSB+1:`KTC_POSTC_LSB];
   assign local_main_state =
      local_state_reg[`KTC_MAIN_LSB+1:`KTC_MAIN_LSB];
   assign local_precursor_state =
      local_state_reg[`KTC_PREC_LSB+1:`KTC_PREC_LSB];

   ////////////////////////////////////////////////////////////////////////
   // Word assembly; reserved bits are tied to zero here and nowhere else
   // Partner request word: 15:14 and 11:10 reserved
   assign partner_req_word = {2'h0, partner_preset_reg, partner_init_reg,
      2'h0, partner_swing_req, partner_post2_req, partner_postcursor_req,
      partner_main_req, partner_precursor_req};
   // Partner status word: ready flag on top, 14:10 reserved
   assign partner_rpt_word = {partner_ready_reg, 5'h00,
      partner_swing_state, partner_post2_state, partner_postcursor_state,
      partner_main_state, partner_precursor_state};
   // Local request word, same layout as the partner request word
   assign local_req_word = {2'h0, local_preset_reg, local_init_reg,
      2'h0, local_swing_req, local_post2_req, local_postcursor_req,
      local_main_req, local_precursor_req};
   // Local status word, same layout as the partner status word
   assign local_rpt_word = {local_ready_reg, 5'h00,
      local_swing_state, local_post2_state, local_postcursor_state,
      local_main_state, local_precursor_state};

   ////////////////////////////////////////////////////////////////////////
   // Read decode; unmapped addresses return zero with no hit
   always @*
   begin
      rdata_next = 16'h0000;
      hit_next = 1'b0;
      if (mgmt_rd && (mgmt_devad == `KTC_DEVAD))
      begin
         hit_next = 1'b1;
         case (mgmt_addr)
            `KTC_PARTNER_REQ_OFS: rdata_next = partner_req_word;
            `KTC_PARTNER_RPT_OFS: rdata_next = partner_rpt_word;
            `KTC_LOCAL_REQ_OFS: rdata_next = local_req_word;
            `KTC_LOCAL_RPT_OFS: rdata_next = local_rpt_word;
            default: hit_next = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered read answer; writes are decoded nowhere, so all four
   // words stay read-only and training is never disturbed
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mgmt_rdata <= `KTC_WORD_RST;
         mgmt_hit <= 1'b0;
      end
      else
      begin
         mgmt_rdata <= rdata_next;
         mgmt_hit <= hit_next;
      end
   end

   // Write strobe and data are accepted and deliberately dropped
   wire unused_wr;
   assign unused_wr = mgmt_wr ^ (^mgmt_wdata);

endmodule
`default_nettype wire

/* File: ktc_props.sv */
// Checker on the training word read port
`timescale 1ns/100ps
`default_nettype none
module ktc_props
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Frame received from the partner
   input wire logic rx_frame_valid,
   input wire logic partner_preset_req,
   input wire logic partner_init_req,
   input wire logic partner_receiver_trained,
   input wire logic [9:0] partner_update_req,
   input wire logic [9:0] partner_update_state,
   // Frame sent by the local side
   input wire logic tx_frame_valid,
   input wire logic local_preset_req,
   input wire logic local_init_req,
   input wire logic local_receiver_trained,
   input wire logic [9:0] local_update_req,
   input wire logic [9:0] local_update_state,
   // Management read port
   input wire logic mgmt_rd,
   input wire logic [4:0] mgmt_devad,
   input wire logic [15:0] mgmt_addr,
   input wire logic [15:0] mgmt_rdata,
   input wire logic mgmt_hit
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Read decodes, mapped words are 0x0098 to 0x009b
   wire sel = mgmt_rd && mgmt_devad == 5'h01;
   wire map = sel && mgmt_addr[15:2] == 14'h0026;
   wire r98 = sel && mgmt_addr == 16'h0098;
   wire r99 = sel && mgmt_addr == 16'h0099;
   wire r9a = sel && mgmt_addr == 16'h009a;
   wire r9b = sel && mgmt_addr == 16'h009b;

   property p_hit;
      map |=> mgmt_hit;
   endproperty
   a_hit: assert property (p_hit)
      else $error("read missed");
   property p_miss;
      mgmt_rd && !map |=> !mgmt_hit && !mgmt_rdata;
   endproperty
   a_miss: assert property (p_miss)
      else $error("bad hit");
   property p_idle;
      !mgmt_rd |=> !mgmt_hit && !mgmt_rdata;
   endproperty
   a_idle: assert property (p_idle)
      else $error("stray data");
   property p_rq;
      map && !mgmt_addr[0] |=> !(mgmt_rdata & 16'hcc00);
   endproperty
   a_rq: assert property (p_rq)
      else $error("reserved set");
   property p_rs;
      map && mgmt_addr[0] |=> !(mgmt_rdata & 16'h7c00);
   endproperty
   a_rs: assert property (p_rs)
      else $error("reserved set");
   property p_pre;
      rx_frame_valid ##1 r98 |=>
         mgmt_rdata[13] == $past(partner_preset_req, 2) &&
         mgmt_rdata[12] == $past(partner_init_req, 2);
   endproperty
   a_pre: assert property (p_pre)
      else $error("preset bad");
   property p_req;
      rx_frame_valid ##1 r98 |=>
         mgmt_rdata[9:0] == $past(partner_update_req, 2);
   endproperty
   a_req: assert property (p_req)
      else $error("request bad");
   property p_rdy;
      rx_frame_valid ##1 r99 |=>
         mgmt_rdata[15] == $past(partner_receiver_trained, 2) &&
         mgmt_rdata[9:0] == $past(partner_update_state, 2);
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("status bad");
   property p_lrq;
      tx_frame_valid ##1 r9a |=> mgmt_rdata == {2'h0,
         $past(local_preset_req, 2), $past(local_init_req, 2), 2'h0,
         $past(local_update_req, 2)};
   endproperty
   a_lrq: assert property (p_lrq)
      else $error("local request bad");
   property p_lrs;
      tx_frame_valid ##1 r9b |=> mgmt_rdata == {
         $past(local_receiver_trained, 2), 5'h00,
         $past(local_update_state, 2)};
   endproperty
   a_lrs: assert property (p_lrs)
      else $error("local status bad");
   c_lp: cover property (rx_frame_valid ##1 r98);
   c_ld: cover property (tx_frame_valid ##1 r9a);
   c_miss: cover property (mgmt_rd && !map);
   c_b2b: cover property (mgmt_hit ##1 mgmt_hit);
endmodule

// Attach the checker to every copy of the block
bind ktc_training_coeff_regs ktc_props u_props
(
   .clk(clk),
   .rst_n(rst_n),
   .rx_frame_valid(rx_frame_valid),
   .partner_preset_req(partner_preset_req),
   .partner_init_req(partner_init_req),
   .partner_receiver_trained(partner_receiver_trained),
   .partner_update_req(partner_update_req),
   .partner_update_state(partner_update_state),
   .tx_frame_valid(tx_frame_valid),
   .local_preset_req(local_preset_req),
   .local_init_req(local_init_req),
   .local_receiver_trained(local_receiver_trained),
   .local_update_req(local_update_req),
   .local_update_state(local_update_state),
   .mgmt_rd(mgmt_rd),
   .mgmt_devad(mgmt_devad),
   .mgmt_addr(mgmt_addr),
   .mgmt_rdata(mgmt_rdata),
   .mgmt_hit(mgmt_hit)
);
`default_nettype wire

/* File: ktc_partner.sv */
// Far-end frame source, one frame per call
`timescale 1ns/100ps
`default_nettype none
module ktc_partner
(
   // Clock shared with the block
   input wire logic clk,
   // Frame strobe and the fields that it carries
   output wire logic rx_frame_valid,
   output wire logic partner_preset_req,
   output wire logic partner_init_req,
   output wire logic partner_receiver_trained,
   output wire logic [9:0] partner_update_req,
   output wire logic [9:0] partner_update_state
);
   logic [23:0] fld = 24'h000000;
   assign {rx_frame_valid, partner_preset_req, partner_init_req,
      partner_receiver_trained, partner_update_req, partner_update_state} = fld;
   // Fields invert after the frame so a late capture is caught
   task send(input logic [22:0] f);
      @(posedge clk) #1;
      fld = {1'b1, f};
      @(posedge clk) #1;
      fld = {1'b0, ~f};
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Bench for the training coefficient words
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_n = 1'b0, mgmt_rd = 1'b0, mgmt_wr = 1'b0;
   logic [4:0] mgmt_devad = 5'h01;
   logic [15:0] mgmt_addr = 16'h0000, mgmt_wdata = 16'h0000;
   logic [9:0] q, s;
   wire [15:0] mgmt_rdata;
   wire mgmt_hit, rx_frame_valid, partner_preset_req, partner_init_req;
   wire partner_receiver_trained, tx_frame_valid, local_preset_req;
   wire local_init_req, local_receiver_trained;
   wire [9:0] partner_update_req, partner_update_state;
   wire [9:0] local_update_req, local_update_state;
   int fail_count = 0, n_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   ktc_training_coeff_regs i_ktc_training_coeff_regs
   (
      .clk(clk),
      .rst_n(rst_n),
      .rx_frame_valid(rx_frame_valid),
      .partner_preset_req(partner_preset_req),
      .partner_init_req(partner_init_req),
      .partner_update_req(partner_update_req),
      .partner_receiver_trained(partner_receiver_trained),
      .partner_update_state(partner_update_state),
      .tx_frame_valid(tx_frame_valid),
      .local_preset_req(local_preset_req),
      .local_init_req(local_init_req),
      .local_update_req(local_update_req),
      .local_receiver_trained(local_receiver_trained),
      .local_update_state(local_update_state),
      .mgmt_rd(mgmt_rd),
      .mgmt_wr(mgmt_wr),
      .mgmt_devad(mgmt_devad),
      .mgmt_addr(mgmt_addr),
      .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata),
      .mgmt_hit(mgmt_hit)
   );
   ktc_partner lp
   (
      .clk(clk),
      .rx_frame_valid(rx_frame_valid),
      .partner_preset_req(partner_preset_req),
      .partner_init_req(partner_init_req),
      .partner_receiver_trained(partner_receiver_trained),
      .partner_update_req(partner_update_req),
      .partner_update_state(partner_update_state)
   );
   ktc_partner ld(.clk(clk), .rx_frame_valid(tx_frame_valid),
      .partner_preset_req(local_preset_req), .partner_init_req(local_init_req),
      .partner_receiver_trained(local_receiver_trained),
      .partner_update_req(local_update_req),
      .partner_update_state(local_update_state));
   task chk(input logic [16:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Strobe stays up between reads, so back-to-back reads are exercised
   task rd(input logic [4:0] dv, input logic [15:0] a, e, input logic h);
      mgmt_devad = dv;
      mgmt_addr = a;
      mgmt_rd = 1'b1;
      @(posedge clk) #1;
      chk({mgmt_hit, mgmt_rdata}, {h, e});
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task t_reset;
      for (int i = 0; i < 4; i++)
         rd(5'h01, 16'h0098 + 16'(i), 16'h0000,
            1'b1);
      rd(5'h01, 16'h0097, 16'h0000, 1'b0);
      rd(5'h02, 16'h0098, 16'h0000, 1'b0);
      $display("reset test done");
   endtask
   // Every code lands in every field across the four passes
   task t_frames;
      for (int c = 0; c < 4; c++)
      begin
         q = {c[1:0], 2'(c + 1), 2'(c + 2), 2'(c + 3), c[1:0]};
         s = {2'(c + 3), 2'(c + 2), 2'(c + 1), c[1:0], c[1:0]};
         // Each word is read the cycle after its own frame; the frame is
         // sent again before the second word so both get that close look
         lp.send({c[1:0], c[0], q, s});
         rd(5'h01, 16'h0098, {2'h0, c[1:0], 2'h0, q},
            1'b1);
         lp.send({c[1:0], c[0], q, s});
         rd(5'h01, 16'h0099, {c[0], 5'h00, s},
            1'b1);
         ld.send({~c[1:0], c[1], s, q});
         rd(5'h01, 16'h009a, {2'h0, ~c[1:0], 2'h0, s},
            1'b1);
         ld.send({~c[1:0], c[1], s, q});
         rd(5'h01, 16'h009b, {c[1], 5'h00, q}, 1'b1);
      end
      $display("frame test done");
   endtask
   task t_write;
      mgmt_rd = 1'b0;
      mgmt_wr = 1'b1;
      mgmt_wdata = 16'hffff;
      mgmt_addr = 16'h0098;
      @(posedge clk) #1;
      mgmt_wr = 1'b0;
      // A write gives no answer and leaves the word as it was
      chk({mgmt_hit, mgmt_rdata}, 17'h00000);
      rd(5'h01, 16'h0098, {2'h0, 2'h3, 2'h0, q}, 1'b1);
      $display("write test done");
   endtask
   // Reset in mid-run clears the answer at once and every stored word
   task t_rerst;
      mgmt_rd = 1'b0;
      rst_n = 1'b0;
      #1;
      chk({mgmt_hit, mgmt_rdata}, 17'h00000);
      @(posedge clk) #1;
      rst_n = 1'b1;
      t_reset;
      $display("mid-run reset test done");
   endtask
   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset;
      t_frames;
      t_write;
      t_rerst;
      close_out;
   end
   // Run takes well under a hundred cycles
   always @(posedge clk)
      if (++cyc == 1000)
      begin
         fail_count++;
         close_out;
      end
endmodule
`default_nettype wire
